// File: logic/gpd_pkg.sv
// Package with register map, field layouts, reset values and carrier types for the port data block.
`default_nettype none

package gpd_pkg;

  // Port width and data bus width.
  localparam int unsigned PORT_W = 16;
  localparam int unsigned BUS_W  = 32;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [31:0] IDX_PORT_A_PIN_DATA = 32'hFFFF_8382;
  localparam logic [31:0] IDX_PORT_B_PIN_DATA = 32'hFFFF_8390;
  localparam logic [31:0] IDX_PORT_C_PIN_DATA = 32'hFFFF_8392;

  // Implemented bits of each data register; other bits read zero.
  localparam logic [15:0] MASK_PORT_A = 16'hDFFF;
  localparam logic [15:0] MASK_PORT_B = 16'h03FF;
  localparam logic [15:0] MASK_PORT_C = 16'hFFFF;

  // Value of each data register after power-on reset.
  localparam logic [15:0] RST_PORT_A = 16'h0000;
  localparam logic [15:0] RST_PORT_B = 16'h0000;
  localparam logic [15:0] RST_PORT_C = 16'h0000;

  // Byte lanes of the 16-bit register within the bus word.
  localparam int unsigned LANE_LO_LSB = 0;
  localparam int unsigned LANE_HI_LSB = 8;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register select codes returned by the address decoder.
  localparam logic [1:0] SEL_NONE = 2'b00;
  localparam logic [1:0] SEL_A    = 2'b01;
  localparam logic [1:0] SEL_B    = 2'b10;
  localparam logic [1:0] SEL_C    = 2'b11;

  // One bit per pin for each of the three ports.
  typedef struct packed {
    logic [15:0] port_c;
    logic [15:0] port_b;
    logic [15:0] port_a;
  } gpd_pins_t;

  // Write channel states, Gray coded.
  typedef enum logic [1:0] {
    GPD_WR_IDLE = 2'b00,
    GPD_WR_RESP = 2'b01
  } gpd_wr_state_t;

  // Read channel states, Gray coded.
  typedef enum logic [1:0] {
    GPD_RD_IDLE = 2'b00,
    GPD_RD_DATA = 2'b01
  } gpd_rd_state_t;

endpackage

`default_nettype wire

// File: logic/gpd_sync.sv
// Two-stage synchroniser for the pin levels of all ports.
`default_nettype none

module gpd_sync
  import gpd_pkg::*;
(
  // Clock and reset.
  input  wire logic               clock_in,
  input  wire logic               resetn_in,
  // Asynchronous pin levels in, synchronised levels out.
  input  wire gpd_pkg::gpd_pins_t pins_in,
  output var  gpd_pkg::gpd_pins_t pins_out
);

  gpd_pins_t meta_reg;
  gpd_pins_t meta_next;
  gpd_pins_t sync_next;

  // The first stage feeds only the second stage.
  always_comb
  begin
    meta_next = pins_in;
    sync_next = meta_reg;
  end

  // Both stages clear on reset so reads start from a known level.
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      meta_reg <= '0;
      pins_out <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      pins_out <= sync_next;
    end
  end

endmodule

`default_nettype wire

// File: logic/gpd_port_data.sv
// Data registers of three I/O ports with pin drive and an AXI4-Lite register slave.
//
// Local design decision: the AXI4-Lite register port.
`default_nettype none

module gpd_port_data
  import gpd_pkg::*;
#(
  parameter int unsigned ADDR_W = 14
)
(
  // Clock and synchronous power-on reset.
  input  wire logic               clock_in,
  input  wire logic               resetn_in,
  // AXI4-Lite write address channel.
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr_in,
  input  wire logic               s_axi_awvalid_in,
  output var  logic               s_axi_awready_out,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]        s_axi_wdata_in,
  input  wire logic [3:0]         s_axi_wstrb_in,
  input  wire logic               s_axi_wvalid_in,
  output var  logic               s_axi_wready_out,
  // AXI4-Lite write response channel.
  output var  logic [1:0]         s_axi_bresp_out,
  output var  logic               s_axi_bvalid_out,
  input  wire logic               s_axi_bready_in,
  // AXI4-Lite read address channel.
  input  wire logic [ADDR_W-1:0]  s_axi_araddr_in,
  input  wire logic               s_axi_arvalid_in,
  output var  logic               s_axi_arready_out,
  // AXI4-Lite read data channel.
  output var  logic [31:0]        s_axi_rdata_out,
  output var  logic [1:0]         s_axi_rresp_out,
  output var  logic               s_axi_rvalid_out,
  input  wire logic               s_axi_rready_in,
  // Pin function and direction from the pin function controller.
  input  wire gpd_pkg::gpd_pins_t general_func_in,
  input  wire gpd_pkg::gpd_pins_t direction_in,
  // Pin levels and pin drive.
  input  wire gpd_pkg::gpd_pins_t pin_level_in,
  output var  gpd_pkg::gpd_pins_t pin_data_out,
  output var  gpd_pkg::gpd_pins_t pin_oe_out
);

  localparam int unsigned IDX_W = ADDR_W - 2;

  // Number of ports, and the implemented pins of all ports side by side.
  localparam int unsigned N_PORTS  = 3;
  localparam logic [47:0] PIN_MASK = {MASK_PORT_C, MASK_PORT_B, MASK_PORT_A};

  // How the block behaves on its bus:
  // - A write commits one edge after both its address and its data are held; the
  //   response rises together with the new register value, so a driven pin moves with it.
  // - A read samples the register and the synchronised pins at its address hand-shake
  //   and answers on the next edge; a pin change is visible two edges after it is seen.
  // - At most one write and one read are in flight; the readies stay low until the
  //   response is taken, so no queue is needed on either channel.
  // - Every index bit is decoded, so each of the three registers appears once in the space.
  // - An unmapped access answers with an error and leaves every register untouched.
  // - Only the reset input clears the data registers; nothing else here can.

  // Whole state of the block, apart from the synchroniser flip-flops, in one record.
  typedef struct packed {
    gpd_wr_state_t    wr_state;
    logic             aw_have;
    logic [IDX_W-1:0] aw_idx;
    logic             w_have;
    logic [15:0]      w_data;
    logic [1:0]       w_strb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    gpd_rd_state_t    rd_state;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    gpd_pins_t        data;
    gpd_pins_t        oe;
  } gpd_state_t;

  gpd_state_t state_reg;
  gpd_state_t state_next;
  gpd_pins_t  pin_sync;

  // Flat views of the per-pin buses, so that one loop serves every port.
  logic [47:0]      func_flat;
  logic [47:0]      dir_flat;
  logic [47:0]      sync_flat;
  logic [47:0]      data_flat;
  wire logic [47:0] drive_en;
  wire logic [47:0] read_flat;

  // Decodes a word index to a register select; every index bit is compared.
  function automatic logic [1:0] gpd_decode(input logic [IDX_W-1:0] idx);
    logic [1:0] sel;
    sel = SEL_NONE;
    if (idx == IDX_PORT_A_PIN_DATA[IDX_W-1:0])
    begin
      sel = SEL_A;
    end
    else if (idx == IDX_PORT_B_PIN_DATA[IDX_W-1:0])
    begin
      sel = SEL_B;
    end
    else if (idx == IDX_PORT_C_PIN_DATA[IDX_W-1:0])
    begin
      sel = SEL_C;
    end
    return sel;
  endfunction

  // Per-bit read source: stored bit when direction is 1, live level when 0.
  function automatic logic [15:0] gpd_read_value(
    input logic [15:0] stored,
    input logic [15:0] level,
    input logic [15:0] dir,
    input logic [15:0] mask
  );
    logic [15:0] value;
    value = (stored & dir) | (level & ~dir);
    return value & mask;
  endfunction

  // Merges a write into a register, one byte lane per strobe bit.
  function automatic logic [15:0] gpd_merge(
    input logic [15:0] old,
    input logic [15:0] wdata,
    input logic [1:0]  strb,
    input logic [15:0] mask
  );
    logic [15:0] value;
    value = old;
    if (strb[0])
    begin
      value[LANE_LO_LSB +: 8] = wdata[LANE_LO_LSB +: 8];
    end
    if (strb[1])
    begin
      value[LANE_HI_LSB +: 8] = wdata[LANE_HI_LSB +: 8];
    end
    return value & mask;
  endfunction

  // Pin levels pass two flip-flops before any read can see them.
  gpd_sync u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .pins_in   (pin_level_in),
    .pins_out  (pin_sync)
  );

  // Plain copies of the structured buses.
  assign func_flat = general_func_in;
  assign dir_flat  = direction_in;
  assign sync_flat = pin_sync;
  assign data_flat = state_reg.data;

  // Per port: the drive enable, and the value that a read would return right now.
  for (genvar p = 0; p < N_PORTS; p++)
  begin
    assign drive_en[PORT_W*p +: PORT_W]  = func_flat[PORT_W*p +: PORT_W] & dir_flat[PORT_W*p +: PORT_W]
                                           & PIN_MASK[PORT_W*p +: PORT_W];
    assign read_flat[PORT_W*p +: PORT_W] = gpd_read_value(data_flat[PORT_W*p +: PORT_W],
                                                          sync_flat[PORT_W*p +: PORT_W],
                                                          dir_flat[PORT_W*p +: PORT_W],
                                                          PIN_MASK[PORT_W*p +: PORT_W]);
  end

  // Next-state logic for both bus channels, the data registers and pin drive.
  always_comb
  begin
    logic [1:0]  wsel;
    logic [1:0]  rsel;
    logic [15:0] rval;
    state_next = state_reg;
    wsel       = gpd_decode(state_reg.aw_idx);
    rsel       = gpd_decode(s_axi_araddr_in[ADDR_W-1:2]);
    rval       = 16'h0000;

    // Write address and write data are taken independently, in either order.
    if (s_axi_awvalid_in && state_reg.awready)
    begin
      state_next.aw_have = 1'b1;
      state_next.aw_idx  = s_axi_awaddr_in[ADDR_W-1:2];
    end
    if (s_axi_wvalid_in && state_reg.wready)
    begin
      state_next.w_have = 1'b1;
      state_next.w_data = s_axi_wdata_in[15:0];
      state_next.w_strb = s_axi_wstrb_in[1:0];
    end

    // Write execution and response.
    case (state_reg.wr_state)
      GPD_WR_IDLE:
      begin
        if (state_reg.aw_have && state_reg.w_have)
        begin
          state_next.aw_have  = 1'b0;
          state_next.w_have   = 1'b0;
          state_next.bvalid   = 1'b1;
          state_next.bresp    = RESP_OKAY;
          state_next.wr_state = GPD_WR_RESP;
          // The stored bit always takes the write; the pin only follows it when driven.
          case (wsel)
            SEL_A:
            begin
              state_next.data.port_a = gpd_merge(state_reg.data.port_a, state_reg.w_data,
                                                 state_reg.w_strb, MASK_PORT_A);
            end
            SEL_B:
            begin
              state_next.data.port_b = gpd_merge(state_reg.data.port_b, state_reg.w_data,
                                                 state_reg.w_strb, MASK_PORT_B);
            end
            SEL_C:
            begin
              state_next.data.port_c = gpd_merge(state_reg.data.port_c, state_reg.w_data,
                                                 state_reg.w_strb, MASK_PORT_C);
            end
            default:
            begin
              state_next.bresp = RESP_SLVERR;
            end
          endcase
        end
      end
      GPD_WR_RESP:
      begin
        // The response stands until the master is seen ready for it.
        if (s_axi_bready_in)
        begin
          state_next.bvalid   = 1'b0;
          state_next.wr_state = GPD_WR_IDLE;
        end
      end
      // An unknown state drops any response and returns to idle.
      default:
      begin
        state_next.bvalid   = 1'b0;
        state_next.wr_state = GPD_WR_IDLE;
      end
    endcase

    // A channel is ready again only once its item is used and no response waits.
    state_next.awready = !state_next.aw_have && (state_next.wr_state == GPD_WR_IDLE);
    state_next.wready  = !state_next.w_have && (state_next.wr_state == GPD_WR_IDLE);

    // Read channel: the value is sampled at the address hand-shake.
    case (state_reg.rd_state)
      GPD_RD_IDLE:
      begin
        if (s_axi_arvalid_in && state_reg.arready)
        begin
          state_next.rresp = RESP_OKAY;
          case (rsel)
            SEL_A:
            begin
              rval = read_flat[0 +: PORT_W];
            end
            SEL_B:
            begin
              rval = read_flat[PORT_W +: PORT_W];
            end
            SEL_C:
            begin
              rval = read_flat[2*PORT_W +: PORT_W];
            end
            default:
            begin
              state_next.rresp = RESP_SLVERR;
            end
          endcase
          // The answer is latched here and stands until the master takes it.
          state_next.rdata    = {16'h0000, rval};
          state_next.rvalid   = 1'b1;
          state_next.arready  = 1'b0;
          state_next.rd_state = GPD_RD_DATA;
        end
      end
      GPD_RD_DATA:
      begin
        if (s_axi_rready_in)
        begin
          state_next.rvalid   = 1'b0;
          state_next.arready  = 1'b1;
          state_next.rd_state = GPD_RD_IDLE;
        end
      end
      // An unknown state drops any answer and reopens the address channel.
      default:
      begin
        state_next.rvalid   = 1'b0;
        state_next.arready  = 1'b1;
        state_next.rd_state = GPD_RD_IDLE;
      end
    endcase

    // A pin is driven only when it is a general pin set as output.
    state_next.oe = drive_en;
  end

  // State register; only the power-on reset clears the data registers.
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      // Readies leave reset high, so a request may follow the first edge after it.
      state_reg             <= '0;
      state_reg.wr_state    <= GPD_WR_IDLE;
      state_reg.rd_state    <= GPD_RD_IDLE;
      state_reg.awready     <= 1'b1;
      state_reg.wready      <= 1'b1;
      state_reg.arready     <= 1'b1;
      state_reg.data.port_a <= RST_PORT_A;
      state_reg.data.port_b <= RST_PORT_B;
      state_reg.data.port_c <= RST_PORT_C;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Every output is a field of the state register.
  always_comb
  begin
    s_axi_awready_out = state_reg.awready;
    s_axi_wready_out  = state_reg.wready;
    s_axi_bvalid_out  = state_reg.bvalid;
    s_axi_bresp_out   = state_reg.bresp;
    s_axi_arready_out = state_reg.arready;
    s_axi_rvalid_out  = state_reg.rvalid;
    s_axi_rdata_out   = state_reg.rdata;
    s_axi_rresp_out   = state_reg.rresp;
    pin_data_out      = state_reg.data;
    pin_oe_out        = state_reg.oe;
  end

endmodule

`default_nettype wire

// File: sim/gpd_port_data_assertions.sv
// Concurrent checks on the port data block, bound to its top module.
`default_nettype none
module gpd_port_data_chk
  import gpd_pkg::*;
(
  // Clock and reset.
  input wire logic      clock_in,
  input wire logic      resetn_in,
  // Register bus handshakes.
  input wire logic      s_axi_awvalid_in,
  input wire logic      s_axi_awready_out,
  input wire logic      s_axi_wvalid_in,
  input wire logic      s_axi_wready_out,
  input wire logic      s_axi_bvalid_out,
  input wire logic      s_axi_bready_in,
  input wire logic[1:0] s_axi_bresp_out,
  input wire logic      s_axi_arvalid_in,
  input wire logic      s_axi_arready_out,
  input wire logic      s_axi_rvalid_out,
  input wire logic      s_axi_rready_in,
  input wire logic[31:0] s_axi_rdata_out,
  // Pin side.
  input wire gpd_pkg::gpd_pins_t general_func_in,
  input wire gpd_pkg::gpd_pins_t direction_in,
  input wire gpd_pkg::gpd_pins_t pin_data_out,
  input wire gpd_pkg::gpd_pins_t pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam gpd_pins_t PMASK = {MASK_PORT_C, MASK_PORT_B, MASK_PORT_A};
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Address and data taken together, then the response two edges later.
  sequence both_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence resp_late;
    !s_axi_bvalid_out ##1 s_axi_bvalid_out;
  endsequence
  chk_oe_follow_dir: assert property ($past(resetn_in) |-> pin_oe_out ==
    ($past(general_func_in) & $past(direction_in) & PMASK)) else $error("pin drive enable wrong");
  chk_unimpl_zero: assert property ((pin_data_out & ~PMASK) == 48'h0000_0000_0000)
    else $error("unimplemented pin bit set");
  chk_rdata_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_write_resp: assert property (both_taken |=> resp_late) else $error("write response late");
  chk_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  chk_b_release: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
    !s_axi_bvalid_out && s_axi_awready_out) else $error("write channel not released");
  chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out && !s_axi_arready_out) else $error("read answer missing");
  chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data changed");
  chk_drive_cause: assert property ($changed(pin_data_out) |-> $rose(s_axi_bvalid_out))
    else $error("pin data moved without a write");
endmodule
bind gpd_port_data gpd_port_data_chk u_chk (.clock_in(clock_in), .resetn_in(resetn_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out),
  .general_func_in(general_func_in), .direction_in(direction_in), .pin_data_out(pin_data_out),
  .pin_oe_out(pin_oe_out));
`default_nettype wire

// File: sim/gpd_pin_partner.sv
// Behavioural model of the external pins around the port data block.
`default_nettype none
module gpd_pin_partner
  import gpd_pkg::*;
(
  // Pin drive from the block and the level the outside world puts on undriven pins.
  input  wire gpd_pkg::gpd_pins_t pin_data_in,
  input  wire gpd_pkg::gpd_pins_t pin_oe_in,
  input  wire gpd_pkg::gpd_pins_t ext_level_in,
  // Level seen on each pin.
  output var  gpd_pkg::gpd_pins_t level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin shows the block's data; an undriven one shows the outside level.
  assign level_out = (pin_oe_in & pin_data_in) | (~pin_oe_in & ext_level_in);
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the port data block with its pin partner.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gpd_pkg::*;
  localparam logic [47:0] PAT = 48'h5A5A_C3C3_A5A5;
  localparam logic [13:0] BAD = 14'h0E00;
  logic        clock_in, resetn_in;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  gpd_pins_t   gf, dr, ext, lvl, pdata, oe;
  logic [13:0] adr [3] = '{14'h0E08, 14'h0E40, 14'h0E48};
  logic [15:0] msk [3] = '{MASK_PORT_A, MASK_PORT_B, MASK_PORT_C};
  int          n_errors, checked, i;

  gpd_port_data dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .general_func_in(gf), .direction_in(dr), .pin_level_in(lvl), .pin_data_out(pdata), .pin_oe_out(oe));
  gpd_pin_partner u_pins (.pin_data_in(pdata), .pin_oe_in(oe), .ext_level_in(ext), .level_out(lvl));

  // Free-running clock.
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // Compares of values and of bus responses.
  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    cmp(what, {46'h0, exp}, {46'h0, got});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A handshake that never completes ends the run.
  task automatic hang();
    n_errors++;
    $display("CHECK FAILED handshake expected answer seen timeout");
    results();
  endtask

  // One bus write; bready rises only once bvalid is seen, so the hold is exercised.
  task automatic wr(input logic [13:0] a, input logic [15:0] d, input logic [1:0] s, input logic [1:0] er);
    int k;
    @(posedge clock_in);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0000, d};
    wstrb   <= {2'b00, s};
    wvalid  <= 1'b1;
    for (k = 0; k < 64; k++)
    begin
      @(posedge clock_in);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
        break;
      if (bvalid)
        bready <= 1'b1;
    end
    bready <= 1'b0;
    if (k == 64)
      hang();
    cmp_resp("bresp", er, bresp);
  endtask

  // One bus read with the expected data and response.
  task automatic rd(input logic [13:0] a, input logic [15:0] ed, input logic [1:0] er);
    int k;
    @(posedge clock_in);
    araddr  <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 64; k++)
    begin
      @(posedge clock_in);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
        break;
      if (rvalid)
        rready <= 1'b1;
    end
    rready <= 1'b0;
    if (k == 64)
      hang();
    cmp("rdata", {32'h0000_0000, ed}, {16'h0000, rdata});
    cmp_resp("rresp", er, rresp);
  endtask

  // Sets function, direction and outside level, then lets the synchroniser settle.
  task automatic setp(input logic [47:0] g, input logic [47:0] d, input logic [47:0] e);
    @(posedge clock_in);
    gf  <= g;
    dr  <= d;
    ext <= e;
    repeat (3) @(posedge clock_in);
  endtask

  // Main sequence.
  initial
  begin
    resetn_in = 1'b0;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    {gf, dr, ext} = '0;
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    setp('1, '1, '0);
    for (i = 0; i < 3; i++)
      rd(adr[i], 16'h0000, RESP_OKAY);
    for (i = 0; i < 3; i++)
      wr(adr[i], 16'hFFFF, 2'b11, RESP_OKAY);
    for (i = 0; i < 3; i++)
      rd(adr[i], msk[i], RESP_OKAY);
    cmp("pin level", {MASK_PORT_C, MASK_PORT_B, MASK_PORT_A}, lvl);
    $display("test general output done");
    setp('1, '0, PAT);
    wr(adr[2], 16'h0000, 2'b11, RESP_OKAY);
    cmp("pin level", PAT, lvl);
    for (i = 0; i < 3; i++)
      rd(adr[i], PAT[16*i +: 16] & msk[i], RESP_OKAY);
    setp('1, '1, PAT);
    rd(adr[2], 16'h0000, RESP_OKAY);
    $display("test general input done");
    setp('0, '1, PAT);
    cmp("pin drive", 48'h0000_0000_0000, oe);
    rd(adr[0], MASK_PORT_A, RESP_OKAY);
    wr(adr[0], 16'h2F0F, 2'b11, RESP_OKAY);
    cmp("pin level", PAT, lvl);
    rd(adr[0], 16'h0F0F, RESP_OKAY);
    setp('0, '0, PAT);
    rd(adr[1], PAT[31:16] & MASK_PORT_B, RESP_OKAY);
    $display("test special function done");
    setp('1, '1, '0);
    wr(adr[2], 16'h1234, 2'b01, RESP_OKAY);
    rd(adr[2], 16'h0034, RESP_OKAY);
    wr(adr[2], 16'hABCD, 2'b10, RESP_OKAY);
    wr(adr[2], 16'hFFFF, 2'b00, RESP_OKAY);
    rd(adr[2], 16'hAB34, RESP_OKAY);
    cmp("pin level", {16'hAB34, MASK_PORT_B, 16'h0F0F}, lvl);
    wr(BAD, 16'hFFFF, 2'b11, RESP_SLVERR);
    rd(BAD, 16'h0000, RESP_SLVERR);
    $display("test byte lanes and unmapped done");
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    for (i = 0; i < 3; i++)
      rd(adr[i], 16'h0000, RESP_OKAY);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
